// ---- icl_pkg.sv ----
// Constants, register map and types for the interrupt controller
// Function
// - Global enable set lets enabled interrupts reach the core; clear blocks all.
// - Every reset clears the global interrupt enable.
// - Return-from-interrupt leaves the handler and sets the global enable again.
// - Servicing clears global enable, pushes return address, loads vector 0004h.
// - External event to vector latency is three or four instruction cycles.
// - Each flag sets on its event regardless of its enable or global enable.
// - Clearing global enable suppresses entry due next cycle; request stays pending.
// - External pin is edge triggered; edge select picks rising or falling.
// - Pin enable clear blocks it; enabled pin edge wakes a sleeping core.
// - After interrupt wake-up, vector only when global enable is set.
// - Timer0 overflow from FFh to 00h sets its flag; timer0 enable gates it.
// - Change on a change-enabled port pin sets the change flag; its enable gates.
// - A change during a port read at Q2 start may leave the flag unset.
// - The pin flag may set anywhere within phases Q4 through Q1.
// - Entry saves only the return address; software saves other context.
// - Control register bits 7..0 ordered as documented; resets to 0000 000x.
// - Peripheral flag and enable registers share bit order; both reset zero.
// - Each peripheral interrupt is masked by the enable at its flag position.
// - Interrupt wake resumes at PC+1, then vectors after it when enabled.
package icl_pkg;

  // Register bus geometry and offsets
  localparam int ADR_W = 3;
  localparam logic [ADR_W-1:0] ADR_CORE_CTRL = 3'h0;
  localparam logic [ADR_W-1:0] ADR_PERIPH_EN = 3'h1;
  localparam logic [ADR_W-1:0] ADR_PERIPH_FLG = 3'h2;
  localparam logic [ADR_W-1:0] ADR_PIN_CHG_EN = 3'h3;
  localparam logic [ADR_W-1:0] ADR_EDGE_SEL = 3'h4;

  // Core control register field positions
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int TIMER0_IRQ_ENABLE_BIT = 5;
  localparam int PINE_BIT = 4;
  localparam int CHGE_BIT = 3;
  localparam int T0F_BIT = 2;
  localparam int PINF_BIT = 1;
  localparam int CHGF_BIT = 0;

  // Widths and reset values
  localparam int PORT_W = 6;
  localparam int PC_W = 13;
  localparam logic [7:0] CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] PERIPH_EN_RST = 8'h00;
  localparam logic [7:0] PERIPH_FLG_RST = 8'h00;
  localparam logic [PORT_W-1:0] PIN_CHG_EN_RST = 6'h00;
  localparam logic EDGE_SEL_RST = 1'b1;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  // Instruction cycle phases, Q1 first
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  // Entry sequence, Gray coded along idle -> flush -> vector
  typedef enum logic [1:0] {
    ENT_IDLE = 2'h0,
    ENT_FLUSH = 2'h1,
    ENT_VECT = 2'h3
  } icl_entry_t;

endpackage

// ---- icl_irq_ctrl.sv ----
// Interrupt controller with Wishbone register access and core entry sequence
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module icl_irq_ctrl
  import icl_pkg::*;
(
  input wire logic CLK_SYS, // 40 MHz system clock
  input wire logic RESETN, // Async reset, active low
  input wire logic [ADR_W-1:0] WB_ADR_I, // Register index
  input wire logic [7:0] WB_DAT_I, // Write data
  output logic [7:0] WB_DAT_O, // Read data
  input wire logic WB_SEL_I, // Byte select
  input wire logic WB_WE_I, // Write enable
  input wire logic WB_CYC_I, // Bus cycle
  input wire logic WB_STB_I, // Strobe
  output logic WB_ACK_O, // Acknowledge
  input wire logic EXT_IRQ_PIN, // External interrupt pin
  input wire logic TIMER0_OVF, // Timer0 wrap pulse
  input wire logic [PORT_W-1:0] FIRST_IO_PORT, // Port input levels
  input wire logic PORT_READ, // Core reads the port
  input wire logic [7:0] PERIPH_EVT, // Peripheral event pulses
  input wire logic RETURN_FROM_ISR, // Return instruction executes
  input wire logic CORE_SLEEP, // Core is asleep
  output logic [1:0] Q_PHASE_O, // Current instruction phase
  output logic IRQ_REQ_O, // Enabled request pending
  output logic VECTOR_LOAD_O, // Load PC with vector
  output logic STACK_PUSH_O, // Push return address
  output logic [PC_W-1:0] VECTOR_ADDR_O, // Vector address
  output logic WAKE_O // Leave sleep
);

  // Register write decode, used for every register
  function automatic logic reg_wr(input logic en,
                                  input logic [ADR_W-1:0] adr,
                                  input logic [ADR_W-1:0] target);
    reg_wr = en && (adr == target);
  endfunction

  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [7:0] core_q;
  logic [7:0] core_d;
  logic [7:0] pie_q;
  logic [7:0] pie_d;
  logic [7:0] pir_q;
  logic [7:0] pir_d;
  logic [PORT_W-1:0] ioc_q;
  logic [PORT_W-1:0] ioc_d;
  logic edge_q;
  logic edge_d;
  logic pin_prev_q;
  logic [PORT_W-1:0] port_prev_q;
  logic ack_q;
  logic [7:0] rdat_q;
  logic [7:0] rdat_d;
  icl_entry_t st_q;
  icl_entry_t st_d;

  // Phase divider: one instruction cycle is four system clocks
  wire q4_en = (phase_q == PH_Q4);
  assign phase_d = phase_q + PH_STEP;

  // Bus decode; a write lands on the edge where the master sees ack
  wire bus_req = WB_CYC_I && WB_STB_I;
  wire wr_en = bus_req && WB_WE_I && WB_SEL_I && ack_q;
  wire wr_core = reg_wr(wr_en, WB_ADR_I, ADR_CORE_CTRL);
  wire wr_pie = reg_wr(wr_en, WB_ADR_I, ADR_PERIPH_EN);
  wire wr_pir = reg_wr(wr_en, WB_ADR_I, ADR_PERIPH_FLG);
  wire wr_ioc = reg_wr(wr_en, WB_ADR_I, ADR_PIN_CHG_EN);
  wire wr_edge = reg_wr(wr_en, WB_ADR_I, ADR_EDGE_SEL);

  // Read mux; unmapped indices read as zero but are still acked
  assign rdat_d =
    (WB_ADR_I == ADR_CORE_CTRL) ? core_q :
    (WB_ADR_I == ADR_PERIPH_EN) ? pie_q :
    (WB_ADR_I == ADR_PERIPH_FLG) ? pir_q :
    (WB_ADR_I == ADR_PIN_CHG_EN) ? {2'h0, ioc_q} :
    (WB_ADR_I == ADR_EDGE_SEL) ? {7'h00, edge_q} : 8'h00;

  // Pin sampled only in Q4 and Q1, so its flag sets within that window
  wire pin_win = (phase_q == PH_Q4) || (phase_q == PH_Q1);
  wire pin_rise = EXT_IRQ_PIN && !pin_prev_q;
  wire pin_fall = !EXT_IRQ_PIN && pin_prev_q;
  wire pin_set = pin_win && (edge_q ? pin_rise : pin_fall);

  // Port change; a change meeting a Q2 read is dropped, not queued
  wire port_rd_q2 = PORT_READ && (phase_q == PH_Q2);
  wire chg_hit = |((FIRST_IO_PORT ^ port_prev_q) & ioc_q);
  wire chg_set = chg_hit && !port_rd_q2;

  // Flag sets win over a software write in the same cycle
  wire [7:0] core_base = wr_core ? WB_DAT_I : core_q;
  wire [2:0] core_set = {TIMER0_OVF, pin_set, chg_set};
  wire vect_fire;
  wire gie_d = vect_fire ? 1'b0 :
               RETURN_FROM_ISR ? 1'b1 : core_base[GIE_BIT];
  // Enables pass through; flag bits OR in the hardware sets
  assign core_d = {gie_d, core_base[PERIPHERAL_IRQ_ENABLE_BIT:CHGE_BIT],
                   core_base[T0F_BIT:CHGF_BIT] | core_set};
  assign pie_d = wr_pie ? WB_DAT_I : pie_q;
  assign pir_d = (wr_pir ? WB_DAT_I : pir_q) | PERIPH_EVT;
  assign ioc_d = wr_ioc ? WB_DAT_I[PORT_W-1:0] : ioc_q;
  assign edge_d = wr_edge ? WB_DAT_I[0] : edge_q;

  // Enable/flag pairs line up: bits 5..3 gate bits 2..0
  wire core_pend = |(core_q[TIMER0_IRQ_ENABLE_BIT:CHGE_BIT] & core_q[T0F_BIT:CHGF_BIT]);
  wire per_pend = core_q[PERIPHERAL_IRQ_ENABLE_BIT] && |(pie_q & pir_q);
  wire any_pend = core_pend || per_pend;
  wire global_irq_enable = core_q[GIE_BIT];
  wire irq_req = global_irq_enable && any_pend;
  // Wake ignores global enable; the core resumes at PC+1 either way
  wire wake = CORE_SLEEP && any_pend;

  // Entry sequence advances only at instruction boundaries
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ENT_IDLE:
        if (q4_en && irq_req && !CORE_SLEEP)
          st_d = ENT_FLUSH;
      ENT_FLUSH:
        if (!global_irq_enable)
          st_d = ENT_IDLE;
        else if (q4_en)
          st_d = ENT_VECT;
      ENT_VECT:
        if (!global_irq_enable)
          st_d = ENT_IDLE;
        else if (q4_en)
          st_d = ENT_IDLE;
      default:
        st_d = ENT_IDLE;
    endcase
  end

  // Vector taken at the third boundary: three or four cycles from event
  assign vect_fire = q4_en && (st_q == ENT_VECT) && global_irq_enable;

  // Phase counter and entry state
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      phase_q <= PH_Q1;
      st_q <= ENT_IDLE;
    end
    else
    begin
      phase_q <= phase_d;
      st_q <= st_d;
    end
  end

  // Interrupt registers; reset drops global enable
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      core_q <= CORE_CTRL_RST;
      pie_q <= PERIPH_EN_RST;
      pir_q <= PERIPH_FLG_RST;
      ioc_q <= PIN_CHG_EN_RST;
      edge_q <= EDGE_SEL_RST;
    end
    else
    begin
      core_q <= core_d;
      pie_q <= pie_d;
      pir_q <= pir_d;
      ioc_q <= ioc_d;
      edge_q <= edge_d;
    end
  end

  // Input history for edge and change detection
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pin_prev_q <= 1'b0;
      port_prev_q <= '0;
    end
    else
    begin
      if (pin_win)
        pin_prev_q <= EXT_IRQ_PIN;
      port_prev_q <= FIRST_IO_PORT;
    end
  end

  // Bus answer: one wait state, ack lasts one cycle
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ack_q <= 1'b0;
      rdat_q <= 8'h00;
    end
    else
    begin
      ack_q <= bus_req && !ack_q;
      rdat_q <= rdat_d;
    end
  end

  // Core-facing outputs, all registered; only the PC is pushed
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      IRQ_REQ_O <= 1'b0;
      VECTOR_LOAD_O <= 1'b0;
      STACK_PUSH_O <= 1'b0;
      VECTOR_ADDR_O <= IRQ_VECTOR;
      WAKE_O <= 1'b0;
    end
    else
    begin
      IRQ_REQ_O <= irq_req;
      VECTOR_LOAD_O <= vect_fire;
      STACK_PUSH_O <= vect_fire;
      VECTOR_ADDR_O <= IRQ_VECTOR;
      WAKE_O <= wake;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign Q_PHASE_O = phase_q;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  gie_cleared_entry_a: assert property (
    VECTOR_LOAD_O |-> !global_irq_enable && STACK_PUSH_O)
    else $error("global enable still set after vector load");
  vector_fixed_a: assert property (
    VECTOR_LOAD_O |-> VECTOR_ADDR_O == IRQ_VECTOR)
    else $error("vector address wrong");
  gie_blocks_a: assert property (
    !global_irq_enable |=> !IRQ_REQ_O)
    else $error("request raised with global enable clear");
  return_sets_a: assert property (
    RETURN_FROM_ISR && !vect_fire |=> global_irq_enable)
    else $error("return did not set global enable");
  timer_flag_a: assert property (
    TIMER0_OVF |=> core_q[T0F_BIT])
    else $error("timer0 flag not set");
  pin_flag_a: assert property (
    pin_set |=> core_q[PINF_BIT])
    else $error("pin flag not set on edge");
  periph_flag_a: assert property (
    |PERIPH_EVT |=> (pir_q & $past(PERIPH_EVT)) == $past(PERIPH_EVT))
    else $error("peripheral flag lost");
  entry_latency_a: assert property (
    VECTOR_LOAD_O |-> $past(st_q == ENT_FLUSH, 5))
    else $error("vector not two boundaries after acceptance");
  pin_wake_a: assert property (
    CORE_SLEEP && core_q[PINE_BIT] && core_q[PINF_BIT] |=> WAKE_O)
    else $error("enabled pin flag did not wake core");
  disable_abort_a: assert property (
    st_q != ENT_IDLE && !global_irq_enable |=> st_q == ENT_IDLE ##1 !VECTOR_LOAD_O)
    else $error("entry continued after global disable");

  vector_taken_c: cover property (VECTOR_LOAD_O);
  wake_seen_c: cover property (WAKE_O ##[1:8] !CORE_SLEEP);
  entry_aborted_c: cover property (st_q == ENT_FLUSH && !global_irq_enable);
  bus_write_c: cover property (wr_core);

endmodule

// ---- icl_core_model.sv ----
// Behavioural core: executes returns, sleeps, counts entries
`timescale 1ns/10ps
module icl_core_model
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic ret_req, // Bench asks for a return
  input wire logic sleep_req, // Bench asks for sleep
  input wire logic vec_load, // Entry strobe
  input wire logic push, // Return address push
  input wire logic wake, // Wake request
  output logic ret_pulse, // Return instruction
  output logic asleep, // Core asleep
  output int entries, // Entries taken
  output int wakes // Wakes taken
);
  // Sleep lasts until the controller wakes the core
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ret_pulse <= 1'b0;
      asleep <= 1'b0;
      entries <= 0;
      wakes <= 0;
    end
    else
    begin
      ret_pulse <= ret_req;
      asleep <= sleep_req | (asleep & ~wake);
      entries <= entries + int'(vec_load & push);
      wakes <= wakes + int'(wake & asleep);
    end
endmodule

// ---- interrupt_controller_logic_test.sv ----
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module interrupt_controller_logic_test;
  import icl_pkg::*;
  logic clk, rst_n, sel, we, cyc, stb, ack, pin, t0, ret, slp, irq;
  logic vl, sp, wake, ret_req, sleep_req, prd;
  logic [ADR_W-1:0] adr;
  logic [7:0] wd, rd, pevt, en, p, r;
  logic [5:0] port, pe, c;
  logic [1:0] q;
  logic [PC_W-1:0] va;
  int fails, checks_done, entries, wakes, n, seed;
  logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  icl_irq_ctrl dut (.CLK_SYS(clk), .RESETN(rst_n), .WB_ADR_I(adr),
    .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_SEL_I(sel), .WB_WE_I(we),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .EXT_IRQ_PIN(pin),
    .TIMER0_OVF(t0), .FIRST_IO_PORT(port), .PORT_READ(prd),
    .PERIPH_EVT(pevt), .RETURN_FROM_ISR(ret), .CORE_SLEEP(slp),
    .Q_PHASE_O(q), .IRQ_REQ_O(irq), .VECTOR_LOAD_O(vl),
    .STACK_PUSH_O(sp), .VECTOR_ADDR_O(va), .WAKE_O(wake));
  icl_core_model core (.clk(clk), .rst_n(rst_n), .ret_req(ret_req),
    .sleep_req(sleep_req), .vec_load(vl), .push(sp), .wake(wake),
    .ret_pulse(ret), .asleep(slp), .entries(entries), .wakes(wakes));
  always #12.5 clk = ~clk;
  task automatic stop_test;
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e,
    input logic [12:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle; the wait is bounded, the slave sets the pace
  task automatic bus(input logic w, input logic [ADR_W-1:0] a,
    input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    r = rd;
    if (k >= 20)
      chk("ack", 1, 0);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [ADR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("register", {5'h00, e}, {5'h00, r});
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  // One-cycle request; returns once the global enable has landed
  task automatic do_ret;
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_vec;
    n = 0;
    while (vl !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk("push", 1, sp);
    chk("vector", IRQ_VECTOR, va);
  endtask
  initial
  begin
    #(25 * 6000);
    fails++;
    stop_test();
  end
  initial
  begin
    seed = $urandom(32'h13B8498C);
    {clk, sel, we, cyc, stb, pin, t0, ret_req, sleep_req, prd} = '0;
    {adr, wd, pevt, port} = '0;
    rst_n = 1'b0;
    step(2);
    rst_n <= 1'b1;
    sel <= 1'b1;
    step(1);
    for (int a = 0; a < 6; a++)
      rchk(a[ADR_W-1:0], rst_tab[a]);
    // Timer entry, then a global-enable clear while it is pending
    bus(1'b1, ADR_CORE_CTRL, 8'hA0);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
    wait_vec();
    chk("latency", 1, n >= 9 && n <= 17);
    rchk(ADR_CORE_CTRL, 8'h24);
    bus(1'b1, ADR_CORE_CTRL, 8'hA4);
    bus(1'b1, ADR_CORE_CTRL, 8'h24);
    step(30);
    chk("entries", 1, entries[12:0]);
    do_ret();
    wait_vec();
    bus(1'b1, ADR_CORE_CTRL, 8'h20);
    do_ret();
    rchk(ADR_CORE_CTRL, 8'hA0);
    step(30);
    chk("entries", 2, entries[12:0]);
    bus(1'b1, ADR_CORE_CTRL, 8'h00);
    // Peripheral flags and masks with random values
    repeat (3)
    begin
      en = $urandom;
      p = $urandom;
      bus(1'b1, ADR_PERIPH_FLG, 8'h00);
      bus(1'b1, ADR_PERIPH_EN, en);
      pevt <= p;
      @(posedge clk);
      pevt <= 8'h00;
      rchk(ADR_PERIPH_FLG, p);
      bus(1'b1, ADR_CORE_CTRL, 8'h40);
      chk("irq", 0, irq);
      bus(1'b1, ADR_CORE_CTRL, 8'hC0);
      // Request output is registered, so it follows the write a cycle late
      step(1);
      chk("irq", {12'h000, |(p & en)}, irq);
      bus(1'b1, ADR_CORE_CTRL, 8'h00);
    end
    // Both edge polarities against both edge selections
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADR_CORE_CTRL, 8'h00);
      bus(1'b1, ADR_EDGE_SEL, {7'h00, i[1]});
      pin <= ~pin;
      step(6);
      rchk(ADR_CORE_CTRL, {6'h00, i[1] ^ i[0], 1'b0});
    end
    repeat (3)
    begin
      pe = $urandom;
      c = $urandom;
      bus(1'b1, ADR_CORE_CTRL, 8'h00);
      bus(1'b1, ADR_PIN_CHG_EN, {2'h0, pe});
      port <= port ^ c;
      step(3);
      rchk(ADR_CORE_CTRL, {7'h00, |(c & pe)});
    end
    // Change meeting a port read at the start of Q2 is dropped
    bus(1'b1, ADR_CORE_CTRL, 8'h00);
    bus(1'b1, ADR_PIN_CHG_EN, 8'h3F);
    c = $urandom;
    c[0] = 1'b1;
    while (q !== PH_Q1)
      @(posedge clk);
    port <= port ^ c;
    prd <= 1'b1;
    @(posedge clk);
    prd <= 1'b0;
    step(3);
    rchk(ADR_CORE_CTRL, 8'h00);
    // Pin wake with global enable clear must not vector
    bus(1'b1, ADR_CORE_CTRL, 8'h10);
    bus(1'b1, ADR_EDGE_SEL, 8'h01);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    pin <= 1'b1;
    step(12);
    chk("wakes", 1, wakes[12:0]);
    chk("entries", 2, entries[12:0]);
    // Same wake with global enable set vectors once the core resumes
    pin <= 1'b0;
    step(4);
    bus(1'b1, ADR_CORE_CTRL, 8'h90);
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    pin <= 1'b1;
    step(30);
    chk("wakes", 2, wakes[12:0]);
    chk("entries", 3, entries[12:0]);
    // Mid-run reset; pin back to idle so no false edge follows
    bus(1'b1, ADR_CORE_CTRL, 8'h80);
    bus(1'b1, ADR_EDGE_SEL, 8'h00);
    pin <= 1'b0;
    rst_n <= 1'b0;
    step(2);
    rst_n <= 1'b1;
    step(1);
    rchk(ADR_CORE_CTRL, 8'h00);
    rchk(ADR_EDGE_SEL, 8'h01);
    stop_test();
  end
endmodule
